// ==== verilog/aesl_pkg.sv ====
// package: register map, field positions, event carriers for the error summary logic
package aesl_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] AESL_OFF_SUMMARY   = 8'h00;
    localparam logic [7:0] AESL_OFF_MASK      = 8'h04;
    localparam logic [7:0] AESL_OFF_CONTROL   = 8'h08;
    localparam logic [7:0] AESL_OFF_RESP_ADDR = 8'h0C;
    localparam logic [7:0] AESL_OFF_DMA_ADDR  = 8'h10;

    // ------------------------------------------------------------
    // summary register fields
    // ------------------------------------------------------------
    localparam int AESL_B_CABLE_OK      = 31;
    localparam int AESL_B_NODE_LO       = 20;
    localparam int AESL_B_CMD_LO        = 16;
    localparam int AESL_B_MULTIPLE      = 14;
    localparam int AESL_B_MAP_FIXED     = 13;
    localparam int AESL_B_MAP_FATAL     = 12;
    localparam int AESL_B_BAD_FRAME     = 11;
    localparam int AESL_B_XL_FIXED      = 10;
    localparam int AESL_B_XL_FATAL      = 9;
    localparam int AESL_B_BAD_TARGET    = 8;
    localparam int AESL_B_INTERNAL      = 7;
    localparam int AESL_B_IO_WRITE_FAIL = 6;
    localparam int AESL_B_POWER_FAIL    = 5;
    localparam int AESL_B_A_DATA_PAR    = 4;
    localparam int AESL_B_A_CMDADDR_PAR = 3;

    // write-one-to-clear flags of the summary register
    localparam logic [31:0] AESL_W1C_MASK   = 32'h0000_7FF8;
    // flags that count as a transaction's errors for the multiple-errors flag
    localparam logic [31:0] AESL_TXN_MASK   = 32'h0000_3FD8;
    // flags that lock the responder node, command and address capture
    localparam logic [31:0] AESL_RESP_LOCK  = 32'h0000_30C0;
    // flags that lock the dma address capture
    localparam logic [31:0] AESL_DMA_LOCK   = 32'h0000_0F00;
    // writable bits of the mask register
    localparam logic [31:0] AESL_MASK_BITS  = 32'h8000_0F18;
    localparam int          AESL_B_VEC_EN   = 31;
    // flags whose own mask bit drives the error interrupt
    localparam logic [31:0] AESL_IRQ_DIRECT = 32'h0000_0118;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] AESL_RST_FLAGS  = 32'h0000_0020;
    localparam logic [31:0] AESL_RST_MASK   = 32'h0000_0000;
    localparam logic [1:0]  AESL_RST_MODE   = 2'h0;

    // ------------------------------------------------------------
    // translation modes (control register bits 1:0)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AESL_MODE_NONE = 2'h0,
        AESL_MODE_P512 = 2'h1,
        AESL_MODE_P4K  = 2'h2,
        AESL_MODE_P8K  = 2'h3
    } aesl_mode_t;

    // ------------------------------------------------------------
    // event carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       accept;       // command/address cycle accepted
        logic [5:0] node;
        logic [3:0] command;
        logic [29:0] address;
        logic       fail_write;   // remote could not finish an i/o write
        logic       map_fixed;    // correctable ecc, page map read
        logic       map_fatal;    // uncorrectable ecc, page map read
        logic       map_wr_par;   // internal parity on page map write data
        logic       loop_wr_par;  // loopback write data parity
        logic       loop_rd_par;  // loopback read data parity
    } aesl_resp_ev_t;

    typedef struct packed {
        logic        request;     // dma request presented
        logic        is_write;    // dma write or interrupt
        logic [29:0] vme_addr;
        logic        entry_bad;   // fetched map entry valid bit clear
        logic        xl_fixed;
        logic        xl_fatal;
        logic        a_data_par;
        logic        a_cmdaddr_par;
    } aesl_dma_ev_t;

endpackage

// ==== verilog/aesl_top.sv ====
// adapter error summary register bank with axi4-lite slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
module aesl_top
    import aesl_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // pins from outside the clock domain
    input  wire logic                cables_ok_pin,
    input  wire logic                remote_power_pin,
    input  wire logic                power_fail_pin,
    // same-domain events
    input  wire aesl_resp_ev_t       resp_ev,
    input  wire aesl_dma_ev_t        dma_ev,
    input  wire logic                illegal_state,
    input  wire logic                node_reset_request,
    input  wire logic                self_test_pass,
    // outputs
    output logic                     error_irq,
    output logic                     vectored_write_error_irq,
    output logic                     loop_abort
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AESL_ST_INIT = 3'b001,
        AESL_ST_RUN  = 3'b010,
        AESL_ST_BAD  = 3'b100
    } aesl_state_t;

    typedef struct packed {
        aesl_state_t st;
        logic [2:0]  cab_s;
        logic [2:0]  pwr_s;
        logic [2:0]  acf_s;
        logic        acf_d;
        logic        cable_ok;
        logic [31:0] flags;
        logic [31:0] mask;
        aesl_mode_t  mode;
        logic [5:0]  node;
        logic [3:0]  command;
        logic [29:0] resp_addr;
        logic [29:0] dma_addr;
        logic        aw_hold;
        logic [7:0]  aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
        logic        irq;
        logic        vec_irq;
        logic        abort;
    } aesl_regs_t;

    aesl_regs_t r;
    aesl_regs_t next_r;

    // ------------------------------------------------------------
    // combinational
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] set_v;
        logic [31:0] clr_v;
        logic [31:0] wmask;
        logic [31:0] summary;
        logic        bad_target;
        logic        xl_mode;
        logic        vec;
        logic        do_wr;
        set_v      = '0;
        clr_v      = '0;
        wmask      = '0;
        summary    = '0;
        bad_target = 1'b0;
        xl_mode    = 1'b0;
        vec        = 1'b0;
        do_wr      = 1'b0;
        next_r     = r;

        // two-flop synchronisers; stage 2 feeds logic
        next_r.cab_s = {r.cab_s[1:0], cables_ok_pin};
        next_r.pwr_s = {r.pwr_s[1:0], remote_power_pin};
        next_r.acf_s = {r.acf_s[1:0], power_fail_pin};
        next_r.acf_d = r.acf_s[1];

        // init: sample cables once after reset
        case (r.st)
            AESL_ST_INIT: begin
                next_r.cable_ok = r.cab_s[1] & r.pwr_s[1];
                next_r.st       = AESL_ST_RUN;
            end
            AESL_ST_RUN: begin
                next_r.st = AESL_ST_RUN;
            end
            AESL_ST_BAD: begin
                next_r.st = AESL_ST_RUN;
            end
            default: begin
                next_r.st = AESL_ST_BAD;
            end
        endcase

        // dma target check
        case (r.mode)
            AESL_MODE_NONE, AESL_MODE_P8K: bad_target = dma_ev.vme_addr[29];
            AESL_MODE_P4K:                 bad_target = |dma_ev.vme_addr[29:28];
            AESL_MODE_P512:                bad_target = |dma_ev.vme_addr[28:25];
            default:                       bad_target = 1'b0;
        endcase
        xl_mode = (r.mode != AESL_MODE_NONE);

        // error events
        set_v[AESL_B_MAP_FIXED]     = resp_ev.map_fixed;
        set_v[AESL_B_MAP_FATAL]     = resp_ev.map_fatal;
        set_v[AESL_B_BAD_FRAME]     = dma_ev.request & dma_ev.entry_bad & xl_mode;
        set_v[AESL_B_XL_FIXED]      = dma_ev.request & dma_ev.xl_fixed & xl_mode;
        set_v[AESL_B_XL_FATAL]      = dma_ev.request & dma_ev.xl_fatal & xl_mode;
        set_v[AESL_B_BAD_TARGET]    = dma_ev.request & bad_target;
        set_v[AESL_B_INTERNAL]      = illegal_state | resp_ev.map_wr_par
                                    | resp_ev.loop_wr_par | resp_ev.loop_rd_par;
        set_v[AESL_B_IO_WRITE_FAIL] = resp_ev.fail_write | resp_ev.map_wr_par
                                    | resp_ev.loop_wr_par;
        set_v[AESL_B_POWER_FAIL]    = (r.acf_s[1] & ~r.acf_d) | node_reset_request;
        set_v[AESL_B_A_DATA_PAR]    = dma_ev.a_data_par;
        set_v[AESL_B_A_CMDADDR_PAR] = dma_ev.a_cmdaddr_par;
        // second transaction's errors while earlier ones remain
        set_v[AESL_B_MULTIPLE] = |(set_v & AESL_TXN_MASK) & |(r.flags & AESL_TXN_MASK);
        next_r.abort = resp_ev.loop_wr_par | resp_ev.loop_rd_par;

        // axi write channel capture
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_hold = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_hold = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        next_r.awready = ~next_r.aw_hold & ~r.bvalid;
        next_r.wready  = ~next_r.w_hold & ~r.bvalid;
        if (r.aw_hold && r.w_hold && !r.bvalid) begin
            do_wr          = 1'b1;
            next_r.aw_hold = 1'b0;
            next_r.w_hold  = 1'b0;
            next_r.awready = 1'b0;
            next_r.wready  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = 2'h0;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid  = 1'b0;
            next_r.awready = ~r.aw_hold;
            next_r.wready  = ~r.w_hold;
        end
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{r.w_strb[i]}};
        end
        if (do_wr) begin
            case (r.aw_addr & 8'hFC)
                AESL_OFF_SUMMARY: clr_v = r.w_data & wmask & AESL_W1C_MASK;
                AESL_OFF_MASK:    next_r.mask = (r.mask & ~(wmask & AESL_MASK_BITS))
                                              | (r.w_data & wmask & AESL_MASK_BITS);
                AESL_OFF_CONTROL: if (r.w_strb[0]) next_r.mode = aesl_mode_t'(r.w_data[1:0]);
                AESL_OFF_RESP_ADDR, AESL_OFF_DMA_ADDR: next_r.bresp = 2'h0;
                default:          next_r.bresp = 2'h2;
            endcase
        end
        if (self_test_pass) begin
            clr_v[AESL_B_POWER_FAIL] = 1'b1;
        end
        // set wins over clear
        next_r.flags = ((r.flags & ~clr_v) | set_v) & AESL_W1C_MASK;

        // captures: responder on accept, dma address on request, unless locked
        if (resp_ev.accept && !(|(r.flags & AESL_RESP_LOCK))) begin
            next_r.node      = resp_ev.node;
            next_r.command   = resp_ev.command;
            next_r.resp_addr = resp_ev.address;
        end
        if (dma_ev.request && !(|(r.flags & AESL_DMA_LOCK))) begin
            next_r.dma_addr = dma_ev.vme_addr;
        end

        // error interrupt from current flags, vectored interrupt from this cycle's events
        next_r.irq = |(r.flags & r.mask & AESL_IRQ_DIRECT)
                   | ((r.flags[AESL_B_MAP_FIXED] | r.flags[AESL_B_XL_FIXED]) & r.mask[AESL_B_XL_FIXED])
                   | ((r.flags[AESL_B_MAP_FATAL] | r.flags[AESL_B_XL_FATAL]) & r.mask[AESL_B_XL_FATAL])
                   | (r.flags[AESL_B_BAD_FRAME] & r.mask[AESL_B_BAD_FRAME]);
        vec = (dma_ev.is_write & (set_v[AESL_B_BAD_FRAME] | set_v[AESL_B_XL_FATAL]
                                  | set_v[AESL_B_BAD_TARGET] | set_v[AESL_B_A_CMDADDR_PAR]))
            | set_v[AESL_B_INTERNAL]
            | set_v[AESL_B_IO_WRITE_FAIL]
            | (r.acf_s[1] & ~r.acf_d)
            | set_v[AESL_B_A_DATA_PAR];
        next_r.vec_irq = vec & r.mask[AESL_B_VEC_EN];

        // read channel
        summary = r.flags;
        summary[AESL_B_CABLE_OK] = r.cable_ok;
        summary[AESL_B_NODE_LO +: 6] = r.node;
        summary[AESL_B_CMD_LO +: 4]  = r.command;
        if (s_axi_arvalid && r.arready) begin
            next_r.arready = 1'b0;
            next_r.rvalid  = 1'b1;
            next_r.rresp   = 2'h0;
            case (s_axi_araddr & 8'hFC)
                AESL_OFF_SUMMARY:   next_r.rdata = summary;
                AESL_OFF_MASK:      next_r.rdata = r.mask;
                AESL_OFF_CONTROL:   next_r.rdata = {30'h0, r.mode};
                AESL_OFF_RESP_ADDR: next_r.rdata = {2'h0, r.resp_addr};
                AESL_OFF_DMA_ADDR:  next_r.rdata = {2'h0, r.dma_addr};
                default: begin
                    next_r.rdata = 32'h0;
                    next_r.rresp = 2'h2;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid  = 1'b0;
            next_r.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            r         <= '0;
            // synchronisers keep sampling so the cable bit is valid at release
            r.cab_s   <= next_r.cab_s;
            r.pwr_s   <= next_r.pwr_s;
            r.acf_s   <= next_r.acf_s;
            r.acf_d   <= next_r.acf_d;
            r.st      <= AESL_ST_INIT;
            r.flags   <= AESL_RST_FLAGS;
            r.mask    <= AESL_RST_MASK;
            r.mode    <= aesl_mode_t'(AESL_RST_MODE);
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready            = r.awready;
    assign s_axi_wready             = r.wready;
    assign s_axi_bresp              = r.bresp;
    assign s_axi_bvalid             = r.bvalid;
    assign s_axi_arready            = r.arready;
    assign s_axi_rdata              = r.rdata;
    assign s_axi_rresp              = r.rresp;
    assign s_axi_rvalid             = r.rvalid;
    assign error_irq                = r.irq;
    assign vectored_write_error_irq = r.vec_irq;
    assign loop_abort               = r.abort;

endmodule

// ==== test/aesl_top_chk.sv ====
// checker: port-level timing and field relations of the error summary bank
module aesl_top_chk
    import aesl_pkg::*;
(
    // clock and reset
    input wire logic          clk,
    input wire logic          reset,
    // register bus
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic [7:0]    s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    // events and outputs
    input wire aesl_resp_ev_t resp_ev,
    input wire logic          loop_abort
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [7:0] rd_addr;
    // address of the read in flight
    always_ff @(posedge clk) begin
        if (reset) rd_addr <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end

    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_loop_par;
        resp_ev.loop_wr_par || resp_ev.loop_rd_par;
    endsequence

    chk_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid) else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_reserved_zero: assert property (s_axi_rvalid && rd_addr == AESL_OFF_SUMMARY |->
        s_axi_rdata[30:26] == 5'h00 && !s_axi_rdata[15]) else $error("reserved bits not zero");
    chk_unmapped_err: assert property (s_axi_rvalid && rd_addr > AESL_OFF_DMA_ADDR |-> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    chk_loop_abort: assert property (s_loop_par |=> loop_abort) else $error("loopback abort missing");
    chk_abort_cause: assert property (loop_abort |-> $past(resp_ev.loop_wr_par || resp_ev.loop_rd_par))
        else $error("abort without cause");
endmodule

bind aesl_top aesl_top_chk i_aesl_top_chk (.*);

// ==== test/aesl_event_src.sv ====
// partner model: commander and dma side event sources
module aesl_event_src
    import aesl_pkg::*;
(
    // clock
    input  wire logic    clk,
    // event lines
    output aesl_resp_ev_t resp_ev,
    output aesl_dma_ev_t  dma_ev,
    output logic          illegal_state,
    output logic          node_reset_request,
    output logic          self_test_pass
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam aesl_resp_ev_t RESP_STB = {1'h1, 40'h0, 6'h3F};
    localparam aesl_dma_ev_t  DMA_STB  = {1'h1, 31'h0, 5'h1F};

    initial begin
        resp_ev = '0;
        dma_ev = '0;
        {illegal_state, node_reset_request, self_test_pass} = 3'h0;
    end

    // one-cycle pulse; released payload shows its inverse
    task automatic pulse(input aesl_resp_ev_t r, input aesl_dma_ev_t d, input logic [2:0] m);
        resp_ev <= r;
        dma_ev <= d;
        {illegal_state, node_reset_request, self_test_pass} <= m;
        @(posedge clk);
        resp_ev <= ~r & ~RESP_STB;
        dma_ev <= ~d & ~DMA_STB;
        {illegal_state, node_reset_request, self_test_pass} <= 3'h0;
    endtask
endmodule

// ==== test/aesl_top_test.sv ====
// testbench: error summary bank over axi4-lite with event stimulus
module aesl_top_test
    import aesl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk = 1'h0;
    logic          reset = 1'h1;
    logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic          s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, power_fail_pin = 1'h0;
    logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]    s_axi_wstrb = 4'hF;
    logic          cables_ok_pin = 1'h1, remote_power_pin = 1'h1;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    aesl_resp_ev_t resp_ev;
    aesl_dma_ev_t  dma_ev;
    logic          illegal_state, node_reset_request, self_test_pass;
    logic          error_irq, vectored_write_error_irq, loop_abort;
    int            failures = 0, samples_checked = 0, vec_n = 0;

    aesl_top i_aesl_top (.*);
    aesl_event_src i_aesl_event_src (.*);

    always #5 clk = ~clk;
    always @(posedge clk) if (vectored_write_error_irq === 1'h1) vec_n <= vec_n + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1 && s_axi_bready !== 1'h1) s_axi_bready <= 1'h1;
        end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
        check({30'h0, s_axi_bresp}, (a > AESL_OFF_DMA_ADDR) ? 32'h2 : 32'h0);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1 && s_axi_rready !== 1'h1) s_axi_rready <= 1'h1;
        end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
        check({30'h0, s_axi_rresp}, (a > AESL_OFF_DMA_ADDR) ? 32'h2 : 32'h0);
        check(s_axi_rdata & m, exp);
        s_axi_rready <= 1'h0;
    endtask

    task automatic ev(input aesl_resp_ev_t r, input aesl_dma_ev_t d, input logic [2:0] m);
        i_aesl_event_src.pulse(r, d, m);
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset_and_map();
        rd_check(AESL_OFF_SUMMARY, 32'h8000_0020, 32'hFFFF_FFFF);
        wr(AESL_OFF_SUMMARY, 32'h8000_0020);
        rd_check(AESL_OFF_SUMMARY, 32'h8000_0000, 32'hFFFF_FFFF);
        wr(AESL_OFF_MASK, 32'hFFFF_FFFF);
        rd_check(AESL_OFF_MASK, 32'h8000_0F18, 32'hFFFF_FFFF);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_check(8'h20, 32'h0, 32'hFFFF_FFFF);
    endtask

    task automatic t_capture();
        aesl_resp_ev_t r;
        r = '0;
        r.accept = 1'h1;
        r.node = 6'h2A;
        r.command = 4'h5;
        r.address = 30'h1234_5678;
        ev(r, '0, 3'h0);
        rd_check(AESL_OFF_SUMMARY, 32'h02A5_0000, 32'h03FF_0000);
        ev(aesl_resp_ev_t'(47'h20), '0, 3'h0);
        r.node = 6'h11;
        r.command = 4'h3;
        r.address = 30'h0ABC_DEF0;
        ev(r, '0, 3'h0);
        wr(AESL_OFF_SUMMARY, 32'h0);
        rd_check(AESL_OFF_SUMMARY, 32'h02A5_0040, 32'h03FF_7FF8);
        rd_check(AESL_OFF_RESP_ADDR, 32'h1234_5678, 32'h3FFF_FFFF);
        wr(AESL_OFF_SUMMARY, 32'hFFFF_FFFF);
        ev(r, '0, 3'h0);
        rd_check(AESL_OFF_SUMMARY, 32'h8113_0000, 32'hFFFF_FFF8);
    endtask

    task automatic t_multiple();
        wr(AESL_OFF_MASK, 32'h0000_0200);
        ev(aesl_resp_ev_t'(47'h20), '0, 3'h0);
        ev(aesl_resp_ev_t'(47'h08), '0, 3'h0);
        rd_check(AESL_OFF_SUMMARY, 32'h0000_5040, 32'h0000_7FF8);
        check({31'h0, error_irq}, 32'h1);
        wr(AESL_OFF_SUMMARY, 32'h0000_7FF8);
        repeat (2) @(posedge clk);
        check({31'h0, error_irq}, 32'h0);
        ev('0, '0, 3'h2);
        ev(aesl_resp_ev_t'(47'h20), '0, 3'h0);
        rd_check(AESL_OFF_SUMMARY, 32'h0000_0060, 32'h0000_7FF8);
        ev('0, '0, 3'h1);
        rd_check(AESL_OFF_SUMMARY, 32'h0000_0040, 32'h0000_7FF8);
        wr(AESL_OFF_SUMMARY, 32'h0000_7FF8);
    endtask

    task automatic t_internal();
        aesl_resp_ev_t r;
        logic [2:0] m;
        int n0;
        wr(AESL_OFF_MASK, 32'h8000_0000);
        for (int i = 0; i < 5; i++) begin
            r = '0;
            m = 3'h0;
            if (i < 3) r[2 - i] = 1'h1;
            else if (i == 3) m = 3'h4;
            else r.fail_write = 1'h1;
            n0 = vec_n;
            ev(r, '0, m);
            check(vec_n - n0, 32'h1);
            rd_check(AESL_OFF_SUMMARY, (i < 2) ? 32'hC0 : (i == 4) ? 32'h40 : 32'h80, 32'h7FF8);
            wr(AESL_OFF_SUMMARY, 32'h0000_7FF8);
        end
    endtask

    task automatic t_modes();
        aesl_dma_ev_t d;
        logic bad, xl;
        int n0;
        for (int md = 0; md < 4; md++) begin
            wr(AESL_OFF_CONTROL, 32'(md));
            for (int j = 0; j < 4; j++) begin
                if (md == 1 && j == 2) continue;
                d = '0;
                d.request = 1'h1;
                d.is_write = 1'h1;
                d.vme_addr = (j == 3) ? 30'h0 : 30'h1 << ((j == 0) ? 25 : 27 + j);
                d.xl_fixed = (j < 3);
                d.entry_bad = (j == 3);
                d.xl_fatal = (j == 3);
                xl = (md != 0);
                bad = (j < 3) && ((md == 0 || md == 3) ? j == 2 : (md == 2) ? j >= 1 : j < 2);
                n0 = vec_n;
                ev('0, d, 3'h0);
                check(vec_n - n0, 32'(bad | (j == 3 && xl)));
                rd_check(AESL_OFF_SUMMARY, (32'(bad) << 8) | ((j < 3) ? 32'(xl) << 10 : xl ? 32'hA00 : 32'h0),
                         32'h0000_7FF8);
                if (bad) rd_check(AESL_OFF_DMA_ADDR, {2'h0, d.vme_addr}, 32'h3FFF_FFFF);
                wr(AESL_OFF_SUMMARY, 32'h0000_7FF8);
            end
        end
    endtask

    task automatic t_chan_a();
        aesl_dma_ev_t d;
        int n0;
        wr(AESL_OFF_MASK, 32'h8000_0008);
        for (int k = 0; k < 3; k++) begin
            d = '0;
            d.is_write = (k == 1);
            d.a_cmdaddr_par = (k < 2);
            d.a_data_par = (k == 2);
            n0 = vec_n;
            ev('0, d, 3'h0);
            check(vec_n - n0, 32'(k != 0));
            check({31'h0, error_irq}, 32'(k < 2));
            rd_check(AESL_OFF_SUMMARY, (k < 2) ? 32'h8 : 32'h10, 32'h0000_7FF8);
            wr(AESL_OFF_SUMMARY, 32'h0000_7FF8);
        end
    endtask

    task automatic t_power();
        int n0;
        wr(AESL_OFF_MASK, 32'h8000_0000);
        n0 = vec_n;
        power_fail_pin <= 1'h1;
        repeat (6) @(posedge clk);
        check(vec_n - n0, 32'h1);
        power_fail_pin <= 1'h0;
        rd_check(AESL_OFF_SUMMARY, 32'h20, 32'h0000_7FF8);
        wr(AESL_OFF_SUMMARY, 32'h20);
        rd_check(AESL_OFF_SUMMARY, 32'h0, 32'h0000_7FF8);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #100us;
        failures++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_reset_and_map();
        t_capture();
        t_multiple();
        t_internal();
        t_modes();
        t_chan_a();
        t_power();
        conclude();
    end
endmodule
